// [design/kpe_keypad_edit.sv]
/*
   Keypad front end: parameter display and digit editing, long-press store with range check,
   and the test running functions, with an APB register file.
   Assumes keys and sequence inputs arrive asynchronously from pins, while motor motion and
   alarm raise strobes come from the servo core on sys_clk.
*/
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module kpe_keypad_edit #(
   parameter int LONG_PRESS_CYC = kpe_pkg::LONG_PRESS_CYC,
   parameter int BLINK_HALF_CYC = kpe_pkg::BLINK_HALF_CYC,
   parameter int STORE_PHASE_CYC = kpe_pkg::STORE_PHASE_CYC
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire kpe_pkg::kpe_apb_req_t apbReq,
   output kpe_pkg::kpe_apb_rsp_t apbRsp,
   input wire kpe_pkg::kpe_keys_t keysIn,
   input wire kpe_pkg::kpe_seq_t seqIn,
   input wire logic motorRotating,
   input wire logic [14:0] alarmRaise,
   output kpe_pkg::kpe_disp_t disp,
   output logic rejectIndication,
   output logic [15:0] feedSpeed,
   output kpe_pkg::kpe_test_t testOut,
   output logic [17:0] commitValue
);
   kpe_pkg::kpe_regs_t st_r;
   kpe_pkg::kpe_regs_t st_nxt;

   function automatic logic [3:0] digitStep(input logic [3:0] d, input logic up);
      logic [3:0] r;
      if (up) begin
         r = (d >= 4'h9) ? 4'h0 : 4'(d + 4'h1);
      end else begin
         r = (d == 4'h0) ? 4'h9 : 4'(d - 4'h1);
      end
      return r;
   endfunction : digitStep

   function automatic logic [17:0] bcdValue(input logic [4:0][3:0] b, input logic n);
      logic [16:0] mag;
      mag = 17'h0;
      for (int i = 4; i >= 0; i--) begin
         mag = 17'(mag * 17'h0000a + {13'h0, b[i]});
      end
      return n ? 18'(-{1'b0, mag}) : {1'b0, mag};
   endfunction : bcdValue

   function automatic logic [3:0] digitAt(input logic [4:0][3:0] b, input logic [2:0] idx,
                                          input logic [2:0] cnt);
      logic [3:0] r;
      r = kpe_pkg::SEG_BLANK;
      if (idx < cnt && idx <= 3'h4) begin
         r = b[idx];
      end
      return r;
   endfunction : digitAt

   function automatic logic [1:0] modeOf(input kpe_pkg::kpe_state_t s);
      logic [1:0] m;
      case (s)
         kpe_pkg::ST_EDIT, kpe_pkg::ST_STORE: m = kpe_pkg::MODE_EDIT;
         kpe_pkg::ST_TEST, kpe_pkg::ST_FEED: m = kpe_pkg::MODE_TEST;
         default: m = kpe_pkg::MODE_SELECT;
      endcase
      return m;
   endfunction : modeOf

   function automatic logic inUpper(input logic [2:0] pos);
      return pos >= 3'h3;
   endfunction : inUpper

   function automatic logic isSplit(input logic [2:0] n);
      return n > 3'h3;
   endfunction : isSplit

   // A count outside one to five would let the edit position index past the five stored digits.
   function automatic logic [2:0] digitCount(input logic [2:0] n);
      logic [2:0] r;
      r = n;
      if (n == 3'h0) begin
         r = 3'h1;
      end else if (n > 3'h5) begin
         r = 3'h5;
      end
      return r;
   endfunction : digitCount

   always_comb begin
      kpe_pkg::kpe_keys_t press;
      logic longPress;
      logic moveBlock;
      logic safetyStop;
      logic [17:0] value;
      logic [2:0] nextSel;
      logic [2:0] selPos;
      logic [2:0] idx;
      logic [14:0] alarmClr;
      logic mapped;
      logic [31:0] rd;
      logic initBlock;
      press = '0;
      longPress = 1'b0;
      moveBlock = 1'b0;
      safetyStop = 1'b0;
      value = 18'h0;
      nextSel = 3'h0;
      selPos = 3'h0;
      idx = 3'h0;
      alarmClr = 15'h0;
      mapped = 1'b0;
      rd = 32'h0;
      initBlock = 1'b0;
      st_nxt = st_r;
      st_nxt.test = '0;

      st_nxt.keySync1 = keysIn;
      st_nxt.keySync2 = st_r.keySync1;
      st_nxt.keyPrev = st_r.keySync2;
      st_nxt.seqSync1 = seqIn;
      st_nxt.seqSync2 = st_r.seqSync1;
      press = kpe_pkg::kpe_keys_t'(st_r.keySync2 & ~st_r.keyPrev);

      // Only a hold reaching the full count fires, and only once; release clears the count.
      if (st_r.keySync2.enter) begin
         if (!st_r.holdFired) begin
            if (st_r.holdCnt == 24'(LONG_PRESS_CYC - 1)) begin
               longPress = 1'b1;
               st_nxt.holdFired = 1'b1;
            end else begin
               st_nxt.holdCnt = 24'(st_r.holdCnt + 24'h1);
            end
         end
      end else begin
         st_nxt.holdCnt = 24'h0;
         st_nxt.holdFired = 1'b0;
      end

      if (st_r.blinkCnt == 24'(BLINK_HALF_CYC - 1)) begin
         st_nxt.blinkCnt = 24'h0;
         st_nxt.blinkOn = ~st_r.blinkOn;
      end else begin
         st_nxt.blinkCnt = 24'(st_r.blinkCnt + 24'h1);
      end

      if (press != '0) begin
         st_nxt.reject = 1'b0;
      end

      safetyStop = st_r.seqSync2.forcedStop | st_r.seqSync2.regenHot | st_r.seqSync2.overtravelInput |
                   st_r.seqSync2.coast;
      moveBlock = (st_r.seqSync2.run & (st_r.seqSync2.forwardCommandInput |
                   st_r.seqSync2.reverseCommandInput)) | motorRotating;
      value = bcdValue(st_r.bcd, st_r.neg);
      nextSel = (st_r.sel >= 3'(st_r.digits - 3'h1)) ? 3'h0 : 3'(st_r.sel + 3'h1);

      case (st_r.state)
         kpe_pkg::ST_EDIT: begin
            if (press.escape) begin
               st_nxt.state = kpe_pkg::ST_SELECT;
            end else if (longPress) begin
               if ($signed(value) < $signed(st_r.rangeMin) || $signed(value) > $signed(st_r.rangeMax)) begin
                  st_nxt.reject = 1'b1;
               end else begin
                  st_nxt.committed = value;
                  st_nxt.test.commit = 1'b1;
                  st_nxt.state = kpe_pkg::ST_STORE;
                  st_nxt.storeCnt = 24'h0;
                  st_nxt.storePhase = 3'h0;
               end
            end else if (press.up || press.down) begin
               st_nxt.bcd[st_r.sel] = digitStep(st_r.bcd[st_r.sel], press.up);
            end else if (press.shift) begin
               st_nxt.sel = nextSel;
               st_nxt.upperHalf = inUpper(nextSel);
            end
         end
         kpe_pkg::ST_STORE: begin
            if (press.escape) begin
               st_nxt.state = kpe_pkg::ST_SELECT;
            end else if (st_r.storeCnt == 24'(STORE_PHASE_CYC - 1)) begin
               st_nxt.storeCnt = 24'h0;
               if (st_r.storePhase == 3'h5) begin
                  st_nxt.state = kpe_pkg::ST_EDIT;
               end else begin
                  st_nxt.storePhase = 3'(st_r.storePhase + 3'h1);
               end
            end else begin
               st_nxt.storeCnt = 24'(st_r.storeCnt + 24'h1);
            end
         end
         kpe_pkg::ST_TEST: begin
            if (press.escape) begin
               st_nxt.state = kpe_pkg::ST_SELECT;
            end else if (longPress) begin
               case (st_r.funcSel)
                  kpe_pkg::FN_MANUAL_FEED: begin
                     if (moveBlock) begin
                        st_nxt.reject = 1'b1;
                     end else begin
                        st_nxt.state = kpe_pkg::ST_FEED;
                     end
                  end
                  kpe_pkg::FN_POS_RESET: begin
                     st_nxt.reject = moveBlock;
                     st_nxt.test.posReset = ~moveBlock;
                  end
                  kpe_pkg::FN_CUM_CLEAR: begin
                     st_nxt.reject = moveBlock;
                     st_nxt.test.cumClear = ~moveBlock;
                  end
                  kpe_pkg::FN_ALARM_RESET: begin
                     alarmClr = kpe_pkg::ALARM_RESETTABLE;
                     st_nxt.test.alarmReset = 1'b1;
                  end
                  kpe_pkg::FN_HIST_CLEAR: begin
                     st_nxt.test.histClear = 1'b1;
                  end
                  kpe_pkg::FN_PARAM_INIT: begin
                     initBlock = st_r.seqSync2.run | st_r.writeProt;
                     st_nxt.reject = initBlock;
                     st_nxt.test.paramInit = ~initBlock;
                  end
                  default: begin
                     st_nxt.reject = 1'b1;
                  end
               endcase
            end
         end
         kpe_pkg::ST_FEED: begin
            // The safety inputs cut feed at once rather than waiting for the operator.
            st_nxt.test.feedFwd = st_r.keySync2.up & ~st_r.keySync2.down & ~safetyStop;
            st_nxt.test.feedRev = st_r.keySync2.down & ~st_r.keySync2.up & ~safetyStop;
            if (press.escape) begin
               st_nxt.state = kpe_pkg::ST_TEST;
               st_nxt.test.feedFwd = 1'b0;
               st_nxt.test.feedRev = 1'b0;
            end
         end
         default: begin
            st_nxt.state = kpe_pkg::ST_SELECT;
         end
      endcase

      // A raise in the same cycle as a reset keeps its alarm latched.
      st_nxt.alarms = (st_r.alarms & ~alarmClr) | alarmRaise;

      for (int p = 0; p < 3; p++) begin
         idx = st_r.upperHalf ? 3'(p + 3) : 3'(p);
         st_nxt.disp.code[p] = digitAt(st_r.bcd, idx, st_r.digits);
      end
      if (isSplit(st_r.digits)) begin
         if (st_r.upperHalf) begin
            st_nxt.disp.code[3] = (st_r.signedPar && st_r.neg) ? kpe_pkg::SEG_MINUS : kpe_pkg::SEG_H;
         end else begin
            st_nxt.disp.code[3] = kpe_pkg::SEG_L;
         end
      end else begin
         st_nxt.disp.code[3] = (st_r.signedPar && st_r.neg) ? kpe_pkg::SEG_MINUS : kpe_pkg::SEG_BLANK;
      end
      selPos = inUpper(st_r.sel) ? 3'(st_r.sel - 3'h3) : st_r.sel;
      case (st_r.state)
         kpe_pkg::ST_EDIT: begin
            st_nxt.disp.lit = 4'hf;
            st_nxt.disp.lit[selPos[1:0]] = st_r.blinkOn;
         end
         kpe_pkg::ST_STORE: st_nxt.disp.lit = st_r.storePhase[0] ? 4'hf : 4'h0;
         default: st_nxt.disp.lit = 4'h0;
      endcase

      // Read data is captured in the setup cycle so the access phase needs no wait state.
      case (apbReq.paddr)
         kpe_pkg::ADDR_CTRL: rd = {21'h0, st_r.funcSel, 1'b0, st_r.writeProt, st_r.signedPar, st_r.digits,
                                   modeOf(st_r.state)};
         kpe_pkg::ADDR_VALUE: rd = {11'h0, st_r.neg, st_r.bcd};
         kpe_pkg::ADDR_RANGE_MIN: rd = {14'h0, st_r.rangeMin};
         kpe_pkg::ADDR_RANGE_MAX: rd = {14'h0, st_r.rangeMax};
         kpe_pkg::ADDR_FEED_SPEED: rd = {16'h0, st_r.feedSpeed};
         kpe_pkg::ADDR_STATUS: rd = {24'h0, 1'b0, st_r.blinkOn, st_r.state == kpe_pkg::ST_FEED,
                                     st_r.state == kpe_pkg::ST_STORE, st_r.reject, st_r.state};
         kpe_pkg::ADDR_ALARM: rd = {17'h0, st_r.alarms};
         kpe_pkg::ADDR_COMMIT: rd = {14'h0, st_r.committed};
         default: rd = 32'h0;
      endcase
      mapped = (apbReq.paddr[1:0] == 2'h0) && (apbReq.paddr <= kpe_pkg::ADDR_COMMIT);
      if (apbReq.psel && !apbReq.penable) begin
         st_nxt.prdata = rd;
         st_nxt.pslverr = ~mapped;
      end

      if (apbReq.psel && apbReq.penable && apbReq.pwrite) begin
         case (apbReq.paddr)
            kpe_pkg::ADDR_CTRL: begin
               st_nxt.digits = digitCount(apbReq.pwdata[kpe_pkg::CTRL_DIGITS_LSB +: 3]);
               st_nxt.signedPar = apbReq.pwdata[kpe_pkg::CTRL_SIGNED_BIT];
               st_nxt.writeProt = apbReq.pwdata[kpe_pkg::CTRL_WPROT_BIT];
               st_nxt.funcSel = apbReq.pwdata[kpe_pkg::CTRL_FUNC_LSB +: 3];
               st_nxt.test.feedFwd = 1'b0;
               st_nxt.test.feedRev = 1'b0;
               case (apbReq.pwdata[kpe_pkg::CTRL_MODE_LSB +: 2])
                  kpe_pkg::MODE_EDIT: begin
                     st_nxt.state = kpe_pkg::ST_EDIT;
                     st_nxt.upperHalf = isSplit(st_nxt.digits);
                     st_nxt.sel = st_nxt.upperHalf ? 3'h3 : 3'h0;
                  end
                  kpe_pkg::MODE_TEST: st_nxt.state = kpe_pkg::ST_TEST;
                  default: st_nxt.state = kpe_pkg::ST_SELECT;
               endcase
            end
            kpe_pkg::ADDR_VALUE: begin
               st_nxt.bcd = apbReq.pwdata[19:0];
               st_nxt.neg = apbReq.pwdata[kpe_pkg::VALUE_SIGN_BIT];
            end
            kpe_pkg::ADDR_RANGE_MIN: st_nxt.rangeMin = apbReq.pwdata[17:0];
            kpe_pkg::ADDR_RANGE_MAX: st_nxt.rangeMax = apbReq.pwdata[17:0];
            kpe_pkg::ADDR_FEED_SPEED: st_nxt.feedSpeed = apbReq.pwdata[15:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_r <= '0;
         st_r.state <= kpe_pkg::ST_SELECT;
         st_r.digits <= kpe_pkg::RST_DIGITS;
         st_r.rangeMin <= kpe_pkg::RST_RANGE_MIN;
         st_r.rangeMax <= kpe_pkg::RST_RANGE_MAX;
         st_r.feedSpeed <= kpe_pkg::RST_FEED_SPEED;
         st_r.blinkOn <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign apbRsp.pready = 1'b1;
   assign apbRsp.prdata = st_r.prdata;
   assign apbRsp.pslverr = st_r.pslverr;
   assign disp = st_r.disp;
   assign rejectIndication = st_r.reject;
   assign feedSpeed = st_r.feedSpeed;
   assign testOut = st_r.test;
   assign commitValue = st_r.committed;
endmodule : kpe_keypad_edit

// [design/kpe_pkg.sv]
/*
   Shared constants and carriers for the keypad parameter edit and test running block.
   Assumes a 10 MHz system clock and an APB master with 32-bit data.
*/
package kpe_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int LONG_PRESS_NS = 1000000000;
   localparam int BLINK_HALF_NS = 500000000;
   localparam int STORE_PHASE_NS = 250000000;
   localparam int LONG_PRESS_CYC = (LONG_PRESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
   localparam int STORE_PHASE_CYC = STORE_PHASE_NS / CLK_PERIOD_NS;

   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_VALUE = 8'h04;
   localparam logic [7:0] ADDR_RANGE_MIN = 8'h08;
   localparam logic [7:0] ADDR_RANGE_MAX = 8'h0c;
   localparam logic [7:0] ADDR_FEED_SPEED = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_ALARM = 8'h18;
   localparam logic [7:0] ADDR_COMMIT = 8'h1c;

   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_DIGITS_LSB = 2;
   localparam int CTRL_SIGNED_BIT = 5;
   localparam int CTRL_WPROT_BIT = 6;
   localparam int CTRL_FUNC_LSB = 8;
   localparam int VALUE_SIGN_BIT = 20;

   localparam logic [1:0] MODE_SELECT = 2'h0;
   localparam logic [1:0] MODE_EDIT = 2'h1;
   localparam logic [1:0] MODE_TEST = 2'h2;

   localparam logic [2:0] RST_DIGITS = 3'h3;
   localparam logic [17:0] RST_RANGE_MIN = 18'h00000;
   localparam logic [17:0] RST_RANGE_MAX = 18'h1869f;
   localparam logic [15:0] RST_FEED_SPEED = 16'h0000;

   localparam int ALARM_W = 15;
   localparam logic [14:0] ALARM_RESETTABLE = 15'h07ff;

   localparam logic [2:0] FN_MANUAL_FEED = 3'h1;
   localparam logic [2:0] FN_POS_RESET = 3'h2;
   localparam logic [2:0] FN_CUM_CLEAR = 3'h3;
   localparam logic [2:0] FN_ALARM_RESET = 3'h4;
   localparam logic [2:0] FN_HIST_CLEAR = 3'h5;
   localparam logic [2:0] FN_PARAM_INIT = 3'h6;

   localparam logic [3:0] SEG_BLANK = 4'ha;
   localparam logic [3:0] SEG_H = 4'hb;
   localparam logic [3:0] SEG_L = 4'hc;
   localparam logic [3:0] SEG_MINUS = 4'hd;

   typedef enum logic [2:0] {
      ST_SELECT = 3'b000,
      ST_EDIT = 3'b001,
      ST_STORE = 3'b010,
      ST_TEST = 3'b011,
      ST_FEED = 3'b100
   } kpe_state_t;

   typedef struct packed {
      logic up;
      logic down;
      logic shift;
      logic enter;
      logic escape;
   } kpe_keys_t;

   typedef struct packed {
      logic run;
      logic forwardCommandInput;
      logic reverseCommandInput;
      logic forcedStop;
      logic regenHot;
      logic overtravelInput;
      logic coast;
   } kpe_seq_t;

   typedef struct packed {
      logic [3:0][3:0] code;
      logic [3:0] lit;
   } kpe_disp_t;

   typedef struct packed {
      logic commit;
      logic feedFwd;
      logic feedRev;
      logic posReset;
      logic cumClear;
      logic alarmReset;
      logic histClear;
      logic paramInit;
   } kpe_test_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } kpe_apb_req_t;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } kpe_apb_rsp_t;

   typedef struct packed {
      kpe_keys_t keySync1;
      kpe_keys_t keySync2;
      kpe_keys_t keyPrev;
      kpe_seq_t seqSync1;
      kpe_seq_t seqSync2;
      kpe_state_t state;
      logic [2:0] digits;
      logic signedPar;
      logic writeProt;
      logic [2:0] funcSel;
      logic [4:0][3:0] bcd;
      logic neg;
      logic [17:0] rangeMin;
      logic [17:0] rangeMax;
      logic [15:0] feedSpeed;
      logic [2:0] sel;
      logic upperHalf;
      logic [23:0] holdCnt;
      logic holdFired;
      logic [23:0] blinkCnt;
      logic blinkOn;
      logic [23:0] storeCnt;
      logic [2:0] storePhase;
      logic reject;
      logic [14:0] alarms;
      logic [17:0] committed;
      kpe_disp_t disp;
      kpe_test_t test;
      logic [31:0] prdata;
      logic pslverr;
   } kpe_regs_t;
endpackage : kpe_pkg

// [test/kpe_operator.sv]
/*
   Operator model for the keypad: presses a key pattern for a number of clock cycles, then releases.
   Assumes each call starts just after a rising edge of sys_clk.
*/
`timescale 1ns/1ns
module kpe_operator (
   input wire logic sys_clk,
   output kpe_pkg::kpe_keys_t keys
);
   initial keys = '0;
   // The release lasts long enough for the sync stages to see every key low again.
   task automatic hold(input kpe_pkg::kpe_keys_t k, input int n);
      keys <= k;
      repeat (n) @(posedge sys_clk);
      keys <= '0;
      repeat (6) @(posedge sys_clk);
   endtask : hold
endmodule : kpe_operator

// [test/kpe_keypad_edit_properties.sv]
/*
   Port assertions for the keypad edit block.
   Assumes a synchronous active-high reset and the bind at the foot of this file.
*/
`timescale 1ns/1ns
module kpe_keypad_edit_checker #(
   parameter int LONG_PRESS_CYC = 20
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire kpe_pkg::kpe_keys_t keysIn,
   input wire kpe_pkg::kpe_seq_t seqIn,
   input wire logic motorRotating,
   input wire kpe_pkg::kpe_test_t testOut,
   input wire logic rejectIndication,
   input wire logic [17:0] commitValue
);
   logic [3:0] enHist;
   int hiCnt;
   logic anyPulse;
   logic safety;
   assign anyPulse = testOut.commit | testOut.posReset | testOut.cumClear | testOut.alarmReset |
                     testOut.histClear | testOut.paramInit;
   assign safety = seqIn.forcedStop | seqIn.regenHot | seqIn.overtravelInput | seqIn.coast;
   // The count survives a short release because the sync stages still carry the press.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         enHist <= 4'h0;
         hiCnt <= 0;
      end else begin
         enHist <= {enHist[2:0], keysIn.enter};
         hiCnt <= (keysIn.enter | (|enHist)) ? hiCnt + int'(keysIn.enter) : 0;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   long_hold_a: assert property (anyPulse |-> hiCnt >= LONG_PRESS_CYC)
      else $error("action without long enter press");
   pulse_single_a: assert property (anyPulse |=> !anyPulse)
      else $error("action pulse longer than one cycle");
   commit_value_a: assert property ($changed(commitValue) |-> testOut.commit)
      else $error("stored value changed without commit");
   commit_clean_a: assert property (testOut.commit |-> !rejectIndication)
      else $error("commit while reject shown");
   motion_refuse_a: assert property ((testOut.posReset || testOut.cumClear) |->
      !motorRotating && !(seqIn.run && (seqIn.forwardCommandInput || seqIn.reverseCommandInput)))
      else $error("reset or clear while motion forbids it");
   init_refuse_a: assert property (testOut.paramInit |-> !seqIn.run)
      else $error("parameter init while running");
   safety_feed_a: assert property (safety [*5] |-> !(testOut.feedFwd || testOut.feedRev))
      else $error("feed while safety input active");
   feed_key_a: assert property (!keysIn.up [*5] |-> !testOut.feedFwd)
      else $error("forward feed without up key");
   reject_nopulse_a: assert property ($rose(rejectIndication) |-> !anyPulse)
      else $error("action pulse together with reject");
endmodule : kpe_keypad_edit_checker

bind kpe_keypad_edit kpe_keypad_edit_checker #(.LONG_PRESS_CYC(LONG_PRESS_CYC)) chk (.sys_clk, .reset,
   .keysIn, .seqIn, .motorRotating, .testOut, .rejectIndication, .commitValue);

// [test/tb.sv]
/*
   Self-checking bench for the keypad edit block: a table of test-running cases, then display,
   edit, store, feed and alarm cases. Assumes the operator model and the bound checker.
*/
`timescale 1ns/1ns
module tb;
   localparam int LP = 20;
   typedef struct packed {
      logic [2:0] fn;
      logic [6:0] seq;
      logic mot;
      logic wp;
      int hold;
      logic [7:0] pulse;
      logic rej;
   } kpe_row_t;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   kpe_pkg::kpe_apb_req_t apbReq = '0;
   kpe_pkg::kpe_apb_rsp_t apbRsp;
   kpe_pkg::kpe_keys_t keysIn;
   kpe_pkg::kpe_seq_t seqIn = '0;
   logic motorRotating = 1'b0;
   logic [14:0] alarmRaise = '0;
   kpe_pkg::kpe_disp_t disp;
   logic rejectIndication;
   logic [15:0] feedSpeed;
   kpe_pkg::kpe_test_t testOut;
   kpe_pkg::kpe_test_t seen;
   logic [17:0] commitValue;
   logic clrSeen = 1'b0;
   int darkCnt;
   int n_mismatch = 0;
   int n_tests = 0;
   logic [31:0] rd;
   kpe_row_t rows [12] = '{'{3'h2, 7'h00, 0, 0, LP + 4, 8'h10, 0}, '{3'h2, 7'h00, 1, 0, LP + 4, 8'h00, 1},
      '{3'h3, 7'h60, 0, 0, LP + 4, 8'h00, 1}, '{3'h3, 7'h50, 0, 0, LP + 4, 8'h00, 1},
      '{3'h3, 7'h40, 0, 0, LP + 4, 8'h08, 0}, '{3'h1, 7'h00, 1, 0, LP + 4, 8'h00, 1},
      '{3'h4, 7'h00, 0, 0, LP - 6, 8'h00, 0}, '{3'h5, 7'h60, 1, 0, LP + 4, 8'h02, 0},
      '{3'h6, 7'h40, 0, 0, LP + 4, 8'h00, 1}, '{3'h6, 7'h00, 0, 1, LP + 4, 8'h00, 1},
      '{3'h6, 7'h00, 0, 0, LP + 4, 8'h01, 0}, '{3'h7, 7'h00, 0, 0, LP + 4, 8'h00, 1}};
   // Each row is control word, value, expected code and code mask.
   logic [95:0] drows [4] = '{{32'h15, 32'h12345, 16'hb000, 16'hf000}, {32'h35, 32'h112345, 16'hd000, 16'hf000},
      {32'h2d, 32'h100012, 16'hd012, 16'hffff}, {32'h0d, 32'h12, 16'ha012, 16'hffff}};

   kpe_keypad_edit #(.LONG_PRESS_CYC(LP), .BLINK_HALF_CYC(8), .STORE_PHASE_CYC(4)) dut (.sys_clk, .reset,
      .apbReq, .apbRsp, .keysIn, .seqIn, .motorRotating, .alarmRaise, .disp, .rejectIndication, .feedSpeed,
      .testOut, .commitValue);
   kpe_operator op (.sys_clk(sys_clk), .keys(keysIn));

   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      seen <= clrSeen ? '0 : (seen | testOut);
      darkCnt <= testOut.commit ? 0 : darkCnt + int'(disp.lit == 4'h0);
   end

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      apbReq.psel <= 1'b1;
      apbReq.pwrite <= w;
      apbReq.paddr <= a;
      apbReq.pwdata <= d;
      @(posedge sys_clk);
      apbReq.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (apbRsp.pready !== 1'b1 && k < 50);
      if (k == 50) begin
         n_mismatch++;
         finish_test();
      end
      rd = apbRsp.prdata;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk

   task automatic press(input kpe_pkg::kpe_keys_t k, input int n);
      clrSeen <= 1'b1;
      @(posedge sys_clk);
      clrSeen <= 1'b0;
      op.hold(k, n);
   endtask : press

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      finish_test();
   end

   initial begin
      int k;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      rdchk(kpe_pkg::ADDR_RANGE_MAX, 32'h1869f);
      rdchk(kpe_pkg::ADDR_FEED_SPEED, 32'h0);
      rdchk(8'h20, 32'h0);
      chk(32'(apbRsp.pslverr), 32'h1);
      foreach (rows[i]) begin
         seqIn <= rows[i].seq;
         motorRotating <= rows[i].mot;
         apb(1'b1, kpe_pkg::ADDR_CTRL, {21'h0, rows[i].fn, 1'b0, rows[i].wp, 6'h0e});
         press(5'h02, rows[i].hold);
         chk(32'(seen), 32'(rows[i].pulse));
         chk(32'(rejectIndication), 32'(rows[i].rej));
         $display("function row %0d done", i);
      end
      seqIn <= '0;
      motorRotating <= 1'b0;
      foreach (drows[i]) begin
         apb(1'b1, kpe_pkg::ADDR_VALUE, drows[i][63:32]);
         apb(1'b1, kpe_pkg::ADDR_CTRL, drows[i][95:64]);
         repeat (3) @(posedge sys_clk);
         chk(32'(disp.code & drows[i][15:0]), 32'(drows[i][31:16]));
      end
      k = 0;
      repeat (16) begin
         @(posedge sys_clk);
         k += int'(disp.lit[0] === 1'b0);
      end
      chk(32'(k), 32'd8);
      $display("display test done");
      apb(1'b1, kpe_pkg::ADDR_RANGE_MIN, 32'h1);
      apb(1'b1, kpe_pkg::ADDR_RANGE_MAX, 32'h7fff);
      apb(1'b1, kpe_pkg::ADDR_VALUE, 32'h39999);
      apb(1'b1, kpe_pkg::ADDR_CTRL, 32'h15);
      press(5'h02, LP + 4);
      chk(32'(rejectIndication), 32'h1);
      chk(32'(seen.commit), 32'h0);
      press(5'h10, 2);
      press(5'h04, 2);
      press(5'h08, 2);
      press(5'h04, 2);
      press(5'h08, 2);
      rdchk(kpe_pkg::ADDR_VALUE, 32'h20998);
      press(5'h02, LP + 4);
      chk(32'(seen.commit), 32'h1);
      chk(32'(commitValue), 32'h05206);
      repeat (40) @(posedge sys_clk);
      chk(32'(darkCnt), 32'd12);
      chk(32'(disp.code), 32'hc998);
      apb(1'b0, kpe_pkg::ADDR_STATUS, 32'h0);
      chk(32'(rd[5:0]), 32'h01);
      press(5'h01, 2);
      apb(1'b0, kpe_pkg::ADDR_STATUS, 32'h0);
      chk(32'(rd[2:0]), 32'h0);
      $display("edit test done");
      apb(1'b1, kpe_pkg::ADDR_FEED_SPEED, 32'h0123);
      chk(32'(feedSpeed), 32'h0123);
      apb(1'b1, kpe_pkg::ADDR_CTRL, 32'h10e);
      press(5'h02, LP + 4);
      press(5'h10, 10);
      chk(32'(seen), 32'h40);
      seqIn <= 7'h02;
      press(5'h08, 10);
      chk(32'(seen), 32'h0);
      seqIn <= '0;
      press(5'h01, 2);
      $display("feed test done");
      alarmRaise <= 15'h7fff;
      @(posedge sys_clk);
      alarmRaise <= 15'h0;
      rdchk(kpe_pkg::ADDR_ALARM, 32'h7fff);
      apb(1'b1, kpe_pkg::ADDR_CTRL, 32'h40e);
      press(5'h02, LP + 4);
      chk(32'(seen), 32'h04);
      rdchk(kpe_pkg::ADDR_ALARM, 32'h7800);
      $display("alarm test done");
      reset <= 1'b1;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      rdchk(kpe_pkg::ADDR_ALARM, 32'h0);
      rdchk(kpe_pkg::ADDR_CTRL, 32'h0c);
      chk(32'(commitValue), 32'h0);
      $display("reset test done");
      finish_test();
   end
endmodule : tb
